// [hdl/spgp_cfg.svh]
// constants for the shared pin general-purpose port
`ifndef SPGP_CFG_SVH
`define SPGP_CFG_SVH

// register bus geometry
`define SPGP_ADDR_W 8
`define SPGP_DATA_W 8

// register offsets
`define SPGP_OFS_CTRL 8'h0E
`define SPGP_OFS_OUT 8'h0F
`define SPGP_OFS_IN 8'h10

// field positions
`define SPGP_NUM_PINS 5
`define SPGP_CTRL_EN_BIT 7
`define SPGP_DIR_MSB 4
`define SPGP_VAL_MSB 4
`define SPGP_PIN_FILTER 4
`define SPGP_MODE_MSB 3

// reset values
`define SPGP_RST_CTRL 8'h00
`define SPGP_RST_OUT 8'h00
`define SPGP_RST_IN 8'h00
`define SPGP_RST_RDATA 8'h00

`endif

// [hdl/spgp_pkg.sv]
// types shared by the shared pin general-purpose port
`include "spgp_cfg.svh"

package spgp_pkg;

   // control register contents as held in flops
   typedef struct packed {
      logic enable;
      logic [`SPGP_DIR_MSB:0] dir;
   } spgp_ctrl_t;

   // role of the five shared pins
   typedef enum logic [1:0] {
      SPGP_ST_SELECT = 2'h1,
      SPGP_ST_GPIO = 2'h2
   } spgp_state_t;

endpackage

// [hdl/spgp_sampler.sv]
// input level sampling register for the shared pins
`timescale 1ns/1ps
`include "spgp_cfg.svh"

module spgp_sampler #(
   parameter int WIDTH = `SPGP_NUM_PINS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // pin levels, synchronous to mclk
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] sampled
);

   logic [WIDTH-1:0] next_sampled;

   // pins are synchronous, so one stage is enough
   always_comb begin
      next_sampled = level;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sampled <= '0;
      end else begin
         sampled <= next_sampled;
      end
   end

endmodule

// [hdl/spgp_pin_cell.sv]
// output driver of one shared pin
`timescale 1ns/1ps

module spgp_pin_cell (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic active,
   input wire logic dir,
   input wire logic drive_value,
   // pad side
   output logic pin_out,
   output logic pin_oe_n
);

   logic drive;
   logic next_pin_out;
   logic next_pin_oe_n;

   // drive only as a general output; the pad stays released otherwise
   always_comb begin
      drive = active & dir;
      next_pin_oe_n = ~drive;
      next_pin_out = drive & drive_value;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_out <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end

endmodule

// [hdl/spgp_port.sv]
// shared pin general-purpose port: registers, role control and pin drive
`timescale 1ns/1ps
`include "spgp_cfg.svh"

module spgp_port
   import spgp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // register port
   input wire logic [`SPGP_ADDR_W-1:0] reg_addr,
   input wire logic [`SPGP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`SPGP_DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // device control mode
   input wire logic spi_mode,
   // shared pins
   input wire logic [`SPGP_NUM_PINS-1:0] general_pins_in,
   output logic [`SPGP_NUM_PINS-1:0] general_pins_out,
   output logic [`SPGP_NUM_PINS-1:0] general_pins_oe_n,
   // selection role towards the rest of the device
   output logic filter_select_level,
   output logic [`SPGP_MODE_MSB:0] mode_select_pin,
   output logic select_role
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   // exact match on the full address; no aliasing of the three registers
   function automatic logic spgp_hit(input logic [`SPGP_ADDR_W-1:0] addr,
                                     input logic [`SPGP_ADDR_W-1:0] ofs);
      spgp_hit = (addr == ofs);
   endfunction

   logic wr_ctrl;
   logic wr_out;
   logic rd_ctrl;
   logic rd_out;
   logic rd_in;

   assign wr_ctrl = reg_wr & spgp_hit(reg_addr, `SPGP_OFS_CTRL);
   assign wr_out = reg_wr & spgp_hit(reg_addr, `SPGP_OFS_OUT);
   assign rd_ctrl = reg_rd & spgp_hit(reg_addr, `SPGP_OFS_CTRL);
   assign rd_out = reg_rd & spgp_hit(reg_addr, `SPGP_OFS_OUT);
   assign rd_in = reg_rd & spgp_hit(reg_addr, `SPGP_OFS_IN);

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   localparam logic [`SPGP_DATA_W-1:0] RST_CTRL = `SPGP_RST_CTRL;
   localparam logic [`SPGP_DATA_W-1:0] RST_OUT = `SPGP_RST_OUT;
   localparam logic [`SPGP_DATA_W-1:0] RST_IN = `SPGP_RST_IN;
   localparam logic [`SPGP_DATA_W-1:0] RST_RDATA = `SPGP_RST_RDATA;

   spgp_ctrl_t ctrl;
   spgp_ctrl_t next_ctrl;
   logic [`SPGP_VAL_MSB:0] out_value;
   logic [`SPGP_VAL_MSB:0] next_out_value;
   logic [`SPGP_VAL_MSB:0] in_value;
   logic [`SPGP_VAL_MSB:0] next_in_value;
   logic [`SPGP_NUM_PINS-1:0] sampled;
   spgp_state_t state;
   spgp_state_t next_state;
   logic gpio_active;

   // reserved bits 6..5 of control are not stored and read back as zero
   always_comb begin
      next_ctrl = ctrl;
      next_out_value = out_value;
      if (wr_ctrl) begin
         next_ctrl.enable = reg_wdata[`SPGP_CTRL_EN_BIT];
         next_ctrl.dir = reg_wdata[`SPGP_DIR_MSB:0];
      end
      if (wr_out) begin
         next_out_value = reg_wdata[`SPGP_VAL_MSB:0];
      end
   end

   // cleared at reset: the port comes up disabled with all pins as inputs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= spgp_ctrl_t'({RST_CTRL[`SPGP_CTRL_EN_BIT], RST_CTRL[`SPGP_DIR_MSB:0]});
         out_value <= RST_OUT[`SPGP_VAL_MSB:0];
      end else begin
         ctrl <= next_ctrl;
         out_value <= next_out_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin role

   // leaving serial control mode takes the pins back at once, even if enabled
   always_comb begin
      next_state = state;
      case (state)
         SPGP_ST_SELECT: begin
            if (ctrl.enable && spi_mode) begin
               next_state = SPGP_ST_GPIO;
            end
         end
         SPGP_ST_GPIO: begin
            if (!ctrl.enable || !spi_mode) begin
               next_state = SPGP_ST_SELECT;
            end
         end
         default: begin
            next_state = SPGP_ST_SELECT;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= SPGP_ST_SELECT;
      end else begin
         state <= next_state;
      end
   end

   assign gpio_active = (state == SPGP_ST_GPIO);

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling and drive

   spgp_sampler #(
      .WIDTH(`SPGP_NUM_PINS)
   ) u_sampler (
      .mclk(mclk),
      .resetn(resetn),
      .level(general_pins_in),
      .sampled(sampled)
   );

   // bit n of direction and output data belongs to pin n; bit 4 is the filter pin
   genvar gi;
   generate
      for (gi = 0; gi < `SPGP_NUM_PINS; gi++) begin : g_pin
         spgp_pin_cell u_cell (
            .mclk(mclk),
            .resetn(resetn),
            .active(gpio_active),
            .dir(ctrl.dir[gi]),
            .drive_value(out_value[gi]),
            .pin_out(general_pins_out[gi]),
            .pin_oe_n(general_pins_oe_n[gi])
         );
      end
   endgenerate

   // only active inputs report a level; other bits read zero
   always_comb begin
      next_in_value = '0;
      if (gpio_active) begin
         next_in_value = sampled & ~ctrl.dir;
      end
   end

   // selection levels follow the pins; select_role tells when they are meaningful
   logic [`SPGP_NUM_PINS-1:0] next_select_levels;
   logic [`SPGP_NUM_PINS-1:0] select_levels;
   logic next_select_role;

   always_comb begin
      next_select_levels = sampled;
      next_select_role = ~gpio_active;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         in_value <= RST_IN[`SPGP_VAL_MSB:0];
         select_levels <= '0;
         select_role <= 1'b1;
      end else begin
         in_value <= next_in_value;
         select_levels <= next_select_levels;
         select_role <= next_select_role;
      end
   end

   assign filter_select_level = select_levels[`SPGP_PIN_FILTER];
   assign mode_select_pin = select_levels[`SPGP_MODE_MSB:0];

   ////////////////////////////////////////////////////////////////////////////
   // read data

   logic [`SPGP_DATA_W-1:0] next_rdata;
   logic next_rvalid;

   // unmapped addresses answer zero; data stands only in the cycle after the read
   always_comb begin
      next_rdata = RST_RDATA;
      next_rvalid = reg_rd;
      if (rd_ctrl) begin
         next_rdata[`SPGP_CTRL_EN_BIT] = ctrl.enable;
         next_rdata[`SPGP_DIR_MSB:0] = ctrl.dir;
      end else if (rd_out) begin
         next_rdata[`SPGP_VAL_MSB:0] = out_value;
      end else if (rd_in) begin
         next_rdata[`SPGP_VAL_MSB:0] = in_value;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= RST_RDATA;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   property p_gpio_needs_spi;
      @(posedge mclk) disable iff (!resetn)
      gpio_active |-> $past(spi_mode);
   endproperty
   a_gpio_needs_spi: assert property (p_gpio_needs_spi) else $error("pins in gpio role outside spi mode");

   property p_disabled_released;
      @(posedge mclk) disable iff (!resetn)
      !ctrl.enable |-> ##2 (&general_pins_oe_n);
   endproperty
   a_disabled_released: assert property (p_disabled_released) else $error("pin driven while disabled");

   property p_enable_enters_gpio;
      @(posedge mclk) disable iff (!resetn)
      (ctrl.enable && spi_mode) |=> gpio_active ##1 !select_role;
   endproperty
   a_enable_enters_gpio: assert property (p_enable_enters_gpio) else $error("global enable did not take pins");

   property p_direction;
      @(posedge mclk) disable iff (!resetn)
      gpio_active |=> (general_pins_oe_n == ~$past(ctrl.dir));
   endproperty
   a_direction: assert property (p_direction) else $error("pin enable does not follow direction");

   property p_filter_pin;
      @(posedge mclk) disable iff (!resetn)
      (gpio_active && ctrl.dir[`SPGP_PIN_FILTER] && out_value[`SPGP_PIN_FILTER])
         |=> (!general_pins_oe_n[`SPGP_PIN_FILTER] && general_pins_out[`SPGP_PIN_FILTER]);
   endproperty
   a_filter_pin: assert property (p_filter_pin) else $error("filter pin not driven by bit 4");

   property p_out_data;
      @(posedge mclk) disable iff (!resetn)
      gpio_active |=> (general_pins_out == ($past(out_value) & $past(ctrl.dir)));
   endproperty
   a_out_data: assert property (p_out_data) else $error("output pin level differs from data");

   property p_in_readback;
      @(posedge mclk) disable iff (!resetn)
      (gpio_active ##1 rd_in) |=> (reg_rdata[`SPGP_VAL_MSB:0] ==
         ($past(sampled, 2) & ~$past(ctrl.dir, 2)));
   endproperty
   a_in_readback: assert property (p_in_readback) else $error("input readback wrong");

   property p_spi_loss_releases;
      @(posedge mclk) disable iff (!resetn)
      !spi_mode |-> ##2 ((&general_pins_oe_n) && select_role);
   endproperty
   a_spi_loss_releases: assert property (p_spi_loss_releases) else $error("pins kept outside spi mode");

   property p_read_answer;
      @(posedge mclk) disable iff (!resetn)
      reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd));
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer not one cycle later");

   // a stale answer would look like a second read to software
   property p_rdata_idle;
      @(posedge mclk) disable iff (!resetn)
      !reg_rd |=> (!reg_rvalid && reg_rdata == RST_RDATA);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared after answer");

   property p_ctrl_write;
      @(posedge mclk) disable iff (!resetn)
      wr_ctrl |=> (ctrl.enable == $past(reg_wdata[`SPGP_CTRL_EN_BIT]) &&
         ctrl.dir == $past(reg_wdata[`SPGP_DIR_MSB:0]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   // main scenarios
   c_enter_gpio: cover property (@(posedge mclk) disable iff (!resetn) !gpio_active ##1 gpio_active);
   c_drive_high: cover property (@(posedge mclk) disable iff (!resetn) gpio_active && (|general_pins_out));
   c_read_input: cover property (@(posedge mclk) disable iff (!resetn) gpio_active && rd_in);
   c_spi_drop: cover property (@(posedge mclk) disable iff (!resetn) gpio_active && !spi_mode);
   c_write_pair: cover property (@(posedge mclk) disable iff (!resetn) wr_ctrl ##1 wr_out);

endmodule

// [testbench/spgp_testbench.sv]
// self-checking testbench for the shared pin general-purpose port
`timescale 1ns/1ps
`include "spgp_cfg.svh"

`define CHK(nm, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
   end \
end

module testbench;

   ////////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   logic mclk;
   logic resetn;
   logic [`SPGP_ADDR_W-1:0] reg_addr;
   logic [`SPGP_DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [`SPGP_DATA_W-1:0] reg_rdata;
   logic reg_rvalid;
   logic spi_mode;
   logic [`SPGP_NUM_PINS-1:0] general_pins_in;
   logic [`SPGP_NUM_PINS-1:0] general_pins_out;
   logic [`SPGP_NUM_PINS-1:0] general_pins_oe_n;
   logic filter_select_level;
   logic [`SPGP_MODE_MSB:0] mode_select_pin;
   logic select_role;
   int fails = 0;
   int samples_checked = 0;
   // direction patterns walked while enabled: filter only, mode only, one, mixed, none
   localparam logic [24:0] DIRS = {5'h10, 5'h0F, 5'h01, 5'h1E, 5'h00};

   spgp_port u_spgp_port (
      .mclk(mclk),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .spi_mode(spi_mode),
      .general_pins_in(general_pins_in),
      .general_pins_out(general_pins_out),
      .general_pins_oe_n(general_pins_oe_n),
      .filter_select_level(filter_select_level),
      .mode_select_pin(mode_select_pin),
      .select_role(select_role)
   );

   // 250 MHz register clock
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus tasks: wait for a rising edge and drive there; one strobe cycle each
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask

   // two writes with no gap; the strobe stays high across both cycles
   task automatic reg_write_pair(input logic [7:0] a0, input logic [7:0] d0, input logic [7:0] a1,
      input logic [7:0] d1);
      @(posedge mclk);
      reg_wr <= 1'h1;
      reg_addr <= a0;
      reg_wdata <= d0;
      @(posedge mclk);
      reg_addr <= a1;
      reg_wdata <= d1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe, so sample there
   task automatic check_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      `CHK("read answer valid", 1'h1, reg_rvalid)
      `CHK(nm, e, reg_rdata)
   endtask

   // role and drive changes land two edges after the control update
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   task automatic check_pins(input logic [4:0] oe_e, input logic [4:0] out_e, input logic role_e);
      `CHK("pin enables", oe_e, general_pins_oe_n)
      `CHK("pin values", out_e, general_pins_out)
      `CHK("selection role", role_e, select_role)
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   initial begin
      #40000;
      fails++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int i;
      logic [4:0] dir;
      logic [4:0] lv;
      resetn = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      spi_mode = 1'h1;
      general_pins_in = 5'h0A;
      repeat (4) @(posedge mclk);
      resetn <= 1'h1;
      #1;
      // reset values and idle pins
      check_reg(`SPGP_OFS_CTRL, 8'h00, "control reset");
      check_reg(`SPGP_OFS_OUT, 8'h00, "output reset");
      check_reg(`SPGP_OFS_IN, 8'h00, "input reset");
      check_pins(5'h1F, 5'h00, 1'h1);
      @(posedge mclk);
      #1;
      `CHK("read answer ends", 1'h0, reg_rvalid)
      `CHK("read data ends", 8'h00, reg_rdata)
      // unmapped place and the read-only input register ignore writes
      reg_write(8'h11, 8'hFF);
      check_reg(8'h11, 8'h00, "unmapped read");
      reg_write(`SPGP_OFS_IN, 8'h1F);
      check_reg(`SPGP_OFS_IN, 8'h00, "input read only");
      // directions and data set while the global enable is clear
      reg_write(`SPGP_OFS_CTRL, 8'h7F);
      reg_write(`SPGP_OFS_OUT, 8'hF5);
      check_reg(`SPGP_OFS_CTRL, 8'h1F, "control readback");
      check_reg(`SPGP_OFS_OUT, 8'h15, "output readback");
      settle();
      check_pins(5'h1F, 5'h00, 1'h1);
      `CHK("filter level idle", 1'h0, filter_select_level)
      `CHK("mode levels idle", 4'hA, mode_select_pin)
      check_reg(`SPGP_OFS_IN, 8'h00, "input while disabled");
      // enabled with each direction pattern
      for (i = 0; i < 5; i++) begin
         dir = DIRS[(4 - i) * 5 +: 5];
         lv = 5'h13 + 5'(i * 5);
         @(posedge mclk);
         general_pins_in <= lv;
         reg_write(`SPGP_OFS_CTRL, {3'h4, dir});
         settle();
         check_pins(~dir, 5'h15 & dir, 1'h0);
         check_reg(`SPGP_OFS_IN, {3'h0, lv & ~dir}, "input levels");
         `CHK("filter level", lv[4], filter_select_level)
         `CHK("mode levels", lv[3:0], mode_select_pin)
      end
      // back-to-back writes, all pins driven
      reg_write_pair(`SPGP_OFS_CTRL, 8'h9F, `SPGP_OFS_OUT, 8'h0A);
      settle();
      check_pins(5'h00, 5'h0A, 1'h0);
      check_reg(`SPGP_OFS_OUT, 8'h0A, "second write of pair");
      // leaving serial-interface control mode releases the pins
      reg_write(`SPGP_OFS_CTRL, 8'h80);
      spi_mode <= 1'h0;
      settle();
      check_pins(5'h1F, 5'h00, 1'h1);
      check_reg(`SPGP_OFS_IN, 8'h00, "input outside mode");
      @(posedge mclk);
      spi_mode <= 1'h1;
      settle();
      check_pins(5'h1F, 5'h00, 1'h0);
      check_reg(`SPGP_OFS_IN, {3'h0, lv}, "input back in mode");
      // clearing the global enable returns the selection role
      reg_write(`SPGP_OFS_CTRL, 8'h1F);
      settle();
      check_pins(5'h1F, 5'h00, 1'h1);
      // second reset in mid-run
      reg_write(`SPGP_OFS_CTRL, 8'h9F);
      resetn <= 1'h0;
      @(posedge mclk);
      resetn <= 1'h1;
      #1;
      check_pins(5'h1F, 5'h00, 1'h1);
      check_reg(`SPGP_OFS_CTRL, 8'h00, "control after reset");
      check_reg(`SPGP_OFS_OUT, 8'h00, "output after reset");
      close_out();
   end

endmodule
